// ### rtl/pabs_pkg.sv
package pabs_pkg;

  // ----------------------------------------------------------------
  // Register select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_PREBLEND  = 2'h0;
  localparam logic [1:0] REG_ST_PLANES = 2'h1;
  localparam logic [1:0] REG_ST_CTRL   = 2'h2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] PREBLEND_RST  = 32'h0000_0000;
  localparam logic [31:0] ST_PLANES_RST = 32'h00ff_0000;
  localparam logic [31:0] ST_CTRL_RST   = 32'h3330_0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PB_SAT_LSB    = 28;
  localparam int PB_M2_LSB     = 2;
  localparam int PB_ADD_BIT    = 0;
  localparam int SP_EN_LSB     = 24;
  localparam int SP_MASK_LSB   = 16;
  localparam int SC_FAIL_LSB   = 28;
  localparam int SC_ZFAIL_LSB  = 24;
  localparam int SC_ZPASS_LSB  = 20;
  localparam int SC_FUNC_LSB   = 16;
  localparam int ALPHA_LSB     = 24;

  // Writable bits; reserved bits are stored as zero.
  localparam logic [31:0] PREBLEND_WMASK  = 32'h3d0d_0d0d;
  localparam logic [31:0] ST_PLANES_WMASK = 32'hffff_0000;
  localparam logic [31:0] ST_CTRL_WMASK   = 32'h7777_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SOP_ZERO = 3'h0, SOP_KEEP = 3'h1, SOP_INVERT = 3'h2, SOP_REPLACE = 3'h3,
    SOP_INCR = 3'h4, SOP_DECR = 3'h5, SOP_INCR2 = 3'h6, SOP_DECR2 = 3'h7
  } pabs_sop_t;

  typedef struct packed {
    logic [7:0] m1;
    logic [8:0] addend;
    logic [7:0] m2;
    logic       loop_addend;
  } pabs_unit_sel_t;

  typedef struct packed {
    logic [31:0] new_data;
    logic [3:0]  extra;
    logic [31:0] old_data;
    logic [31:0] rop_result;
    logic [7:0]  st_ref;
    logic        sat_enable;
    logic        stateless;
    logic [1:0]  pass_in;
    logic        match_pass;
    logic        mag_pass;
  } pabs_pix_in_t;

endpackage

// ### rtl/pabs_alu_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module pabs_alu_ctrl
  import pabs_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    reg_wr,
  input  wire logic [1:0]              reg_sel,
  input  wire logic [31:0]             reg_wdata,
  output logic      [31:0]             reg_rdata,
  input  wire pabs_pkg::pabs_pix_in_t  pix_in,
  output pabs_pkg::pabs_unit_sel_t     unit_sel [4],
  output logic      [7:0]              sat_out,
  output logic      [31:0]             pix_wdata,
  output logic                         pix_we,
  output logic                         pass_out,
  output logic                         unit3_blend_blocked
);
  import pabs_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] preblend_control_q;
  logic [31:0] stencil_planes_q;
  logic [31:0] stencil_control_q;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      preblend_control_q <= PREBLEND_RST;
      stencil_planes_q   <= ST_PLANES_RST;
      stencil_control_q  <= ST_CTRL_RST;
    end
    else if (reg_wr)
    begin
      if (reg_sel == REG_PREBLEND)
        preblend_control_q <= reg_wdata & PREBLEND_WMASK;
      else if (reg_sel == REG_ST_PLANES)
        stencil_planes_q <= reg_wdata & ST_PLANES_WMASK;
      else if (reg_sel == REG_ST_CTRL)
        stencil_control_q <= reg_wdata & ST_CTRL_WMASK;
    end
  end

  wire logic [31:0] rd_pb = (reg_sel == REG_PREBLEND)  ? preblend_control_q : 32'h0000_0000;
  wire logic [31:0] rd_sp = (reg_sel == REG_ST_PLANES) ? stencil_planes_q   : 32'h0000_0000;
  wire logic [31:0] rd_sc = (reg_sel == REG_ST_CTRL)   ? stencil_control_q  : 32'h0000_0000;
  assign reg_rdata = rd_pb | rd_sp | rd_sc;

  // ----------------------------------------------------------------
  // Effective values; stateless writes override the stored state
  // ----------------------------------------------------------------
  wire logic [31:0] pb_eff = pix_in.stateless ? PREBLEND_RST  : preblend_control_q;
  wire logic [31:0] sp_eff = pix_in.stateless ? ST_PLANES_RST : stencil_planes_q;
  wire logic [31:0] sc_eff = pix_in.stateless ? ST_CTRL_RST   : stencil_control_q;

  // ----------------------------------------------------------------
  // Alpha saturate, shared by every unit
  // ----------------------------------------------------------------
  wire logic [7:0] new_a  = pix_in.new_data[ALPHA_LSB +: 8];
  wire logic [7:0] old_a  = pix_in.old_data[ALPHA_LSB +: 8];
  wire logic [7:0] nold_a = ~old_a;
  wire logic [1:0] sat_sel = pb_eff[PB_SAT_LSB +: 2];
  wire logic [7:0] sat_min = (new_a < nold_a) ? new_a : nold_a;

  // Without the saturate enable the block passes new alpha through.
  assign sat_out = !pix_in.sat_enable ? new_a :
                   (sat_sel == 2'h0) ? sat_min :
                   (sat_sel == 2'h1) ? new_a :
                   (sat_sel == 2'h2) ? old_a : nold_a;

  // ----------------------------------------------------------------
  // Per-unit preblend selection
  // ----------------------------------------------------------------
  for (genvar n = 0; n < 4; n++)
  begin : g_unit
    wire logic [3:0] fld  = pb_eff[8*n +: 4];
    wire logic [7:0] nb   = pix_in.new_data[8*n +: 8];
    wire logic [7:0] ob   = pix_in.old_data[8*n +: 8];
    wire logic [1:0] m2s  = fld[PB_M2_LSB +: 2];
    assign unit_sel[n].m1          = nb;
    assign unit_sel[n].addend      = {pix_in.extra[n], nb};
    assign unit_sel[n].m2          = m2s[1] ? sat_out :
                                     (m2s[0] ? ~ob : ob);
    assign unit_sel[n].loop_addend = fld[PB_ADD_BIT];
  end

  // ----------------------------------------------------------------
  // Stencil compare
  // ----------------------------------------------------------------
  wire logic [7:0] st_en   = sp_eff[SP_EN_LSB +: 8];
  wire logic [7:0] st_mask = sp_eff[SP_MASK_LSB +: 8];
  wire logic [7:0] ref_m   = pix_in.st_ref & st_mask;
  wire logic [7:0] old_m   = old_a & st_mask;
  wire logic [2:0] func    = sc_eff[SC_FUNC_LSB +: 3];
  logic            st_pass;

  always_comb
  begin
    case (func)
      3'h0: st_pass = 1'b1;
      3'h1: st_pass = ref_m > old_m;
      3'h2: st_pass = ref_m == old_m;
      3'h3: st_pass = ref_m >= old_m;
      3'h4: st_pass = 1'b0;
      3'h5: st_pass = ref_m <= old_m;
      3'h6: st_pass = ref_m != old_m;
      default: st_pass = ref_m < old_m;
    endcase
  end

  assign unit3_blend_blocked = |st_en;

  // ----------------------------------------------------------------
  // Stencil value as a packed integer of the enabled planes
  // ----------------------------------------------------------------
  logic [3:0] lsb_pos;
  logic [3:0] n_planes;
  always_comb
  begin
    lsb_pos  = 4'h0;
    n_planes = 4'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (st_en[i])
        lsb_pos = 4'(i);
      n_planes = n_planes + {3'h0, st_en[i]};
    end
  end

  // Non-contiguous plane sets still shift and mask, but saturate wrongly.
  wire logic [7:0] st_val  = (old_a & st_en) >> lsb_pos;
  wire logic [8:0] st_max9 = (9'h001 << n_planes) - 9'h001;
  wire logic [7:0] st_max  = st_max9[7:0];
  wire logic [7:0] st_inc  = (st_val >= st_max) ? st_max : st_val + 8'h01;
  wire logic [7:0] st_dec  = (st_val == 8'h00) ? 8'h00 : st_val - 8'h01;

  wire logic       fail_case = !st_pass;
  wire logic       zfail_case = st_pass && !pix_in.mag_pass;
  wire logic [2:0] op_sel =
    fail_case  ? sc_eff[SC_FAIL_LSB +: 3] :
    zfail_case ? sc_eff[SC_ZFAIL_LSB +: 3] :
                 sc_eff[SC_ZPASS_LSB +: 3];
  logic [7:0] st_new;

  always_comb
  begin
    case (pabs_sop_t'(op_sel))
      SOP_ZERO:    st_new = 8'h00;
      SOP_KEEP:    st_new = old_a;
      SOP_INVERT:  st_new = ~old_a;
      SOP_REPLACE: st_new = pix_in.st_ref;
      SOP_INCR, SOP_INCR2: st_new = 8'((st_inc << lsb_pos) & st_en);
      default:     st_new = 8'((st_dec << lsb_pos) & st_en);
    endcase
  end

  // ----------------------------------------------------------------
  // Write data and pass logic
  // ----------------------------------------------------------------
  wire logic       gate_ok = (&pix_in.pass_in) && pix_in.match_pass;
  wire logic       both_pass = st_pass && pix_in.mag_pass;
  wire logic [7:0] free_bits = both_pass ? pix_in.rop_result[ALPHA_LSB +: 8] : old_a;
  wire logic [7:0] top_d = (st_new & st_en) | (free_bits & ~st_en);
  wire logic [31:0] base_d = both_pass ? pix_in.rop_result : pix_in.old_data;

  // Stencil updates write on fail cases, so with any stencil plane enabled the write enable follows the gate only.
  wire logic       we_d = gate_ok && (both_pass || (|st_en));
  wire logic [31:0] wd_d = {top_d, base_d[23:0]};

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pix_wdata <= 32'h0000_0000;
      pix_we    <= 1'b0;
      pass_out  <= 1'b0;
    end
    else
    begin
      pix_wdata <= wd_d;
      pix_we    <= we_d;
      pass_out  <= gate_ok && both_pass;
    end
  end

endmodule

`default_nettype wire

// ### verif/pabs_alu_ctrl_checker.sv
`timescale 1ns/10ps
`default_nettype none
module pabs_alu_ctrl_checker (
  input wire logic                     clk,
  input wire logic                     sys_rst,
  input wire logic                     reg_wr,
  input wire logic [1:0]               reg_sel,
  input wire logic [31:0]              reg_wdata,
  input wire logic [31:0]              reg_rdata,
  input wire pabs_pkg::pabs_pix_in_t   pix_in,
  input wire pabs_pkg::pabs_unit_sel_t unit_sel [4],
  input wire logic [7:0]               sat_out,
  input wire logic [31:0]              pix_wdata,
  input wire logic                     pix_we,
  input wire logic                     pass_out,
  input wire logic                     unit3_blend_blocked
);
  import pabs_pkg::*;
  logic [31:0] pb_q;
  logic [31:0] pb;
  logic [7:0]  na;
  logic [7:0]  nb;
  logic [7:0]  sat;
  logic [3:0]  u_ok;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff sys_rst;
  // A shadow of the preblend register lets the steering be judged on every cycle.
  always_ff @(posedge clk)
    if (sys_rst)
      pb_q <= PREBLEND_RST;
    else if (reg_wr && reg_sel == REG_PREBLEND)
      pb_q <= reg_wdata & PREBLEND_WMASK;
  assign pb = pix_in.stateless ? 32'h0 : pb_q;
  assign na = pix_in.new_data[31:24];
  assign nb = ~pix_in.old_data[31:24];
  assign sat = pb[29] ? (pb[28] ? nb : ~nb) : (pb[28] ? na : (na < nb ? na : nb));
  for (genvar n = 0; n < 4; n++)
  begin : g_unit
    assign u_ok[n] = unit_sel[n].loop_addend == pb[8*n] && unit_sel[n].m2 == (pb[8*n+3]
      ? (pix_in.sat_enable ? sat : na)
      : pb[8*n+2] ? ~pix_in.old_data[8*n+:8] : pix_in.old_data[8*n+:8]);
  end
  a_reset_values:
  assert property ($fell(sys_rst) |-> reg_rdata == (reg_sel == 2'h0 ? PREBLEND_RST
    : reg_sel == 2'h1 ? ST_PLANES_RST : reg_sel == 2'h2 ? ST_CTRL_RST : 32'h0))
    else $error("register value after reset is wrong");
  a_pb_readback:
  assert property (reg_wr && reg_sel == REG_PREBLEND ##1 reg_sel == REG_PREBLEND
    |-> reg_rdata == ($past(reg_wdata) & PREBLEND_WMASK)) else $error("preblend readback wrong");
  a_preblend_fixed:
  assert property (unit_sel[0].m1 == pix_in.new_data[7:0]
    && unit_sel[3].addend == {pix_in.extra[3], na}) else $error("preblend operand wrong");
  a_sat_select:
  assert property (pix_in.sat_enable |-> sat_out == sat) else $error("saturate output wrong");
  a_unit_steer:
  assert property (u_ok == 4'hf) else $error("unit steering wrong");
  a_gate_closed:
  assert property (!(pix_in.pass_in == 2'h3 && pix_in.match_pass) |=> !pass_out && !pix_we)
    else $error("closed gate still writes");
  a_mag_fail_out:
  assert property (!pix_in.mag_pass |=> !pass_out) else $error("pass out despite depth fail");
  a_blocked_flag:
  assert property (reg_sel == REG_ST_PLANES && !pix_in.stateless
    |-> unit3_blend_blocked == |reg_rdata[31:24]) else $error("unit 3 block flag wrong");
endmodule
bind pabs_alu_ctrl pabs_alu_ctrl_checker pabs_alu_ctrl_checker_i (.clk, .sys_rst, .reg_wr,
  .reg_sel, .reg_wdata, .reg_rdata, .pix_in, .unit_sel, .sat_out, .pix_wdata, .pix_we,
  .pass_out, .unit3_blend_blocked);
`default_nettype wire

// ### verif/pabs_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module pabs_ctrl_model (
  input  wire logic              clk,
  input  wire logic [31:0]       reg_rdata,
  output logic                   reg_wr,
  output logic [1:0]             reg_sel,
  output logic [31:0]            reg_wdata,
  output pabs_pkg::pabs_pix_in_t pix_in
);
  import pabs_pkg::*;
  initial
  begin
    reg_wr = 1'b0;
    reg_sel = REG_PREBLEND;
    reg_wdata = 32'h0;
    pix_in = '0;
  end
  task automatic wr(input logic [1:0] sel, input logic [31:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_sel = sel;
    reg_wdata = d & ((sel == REG_PREBLEND) ? PREBLEND_WMASK :
                     (sel == REG_ST_CTRL) ? ST_CTRL_WMASK : ST_PLANES_WMASK);
    @(negedge clk);
    reg_wr = 1'b0;
    // The released data bus is inverted so a design that reads it late cannot get lucky.
    reg_wdata = ~reg_wdata;
  endtask
  task automatic rd(input logic [1:0] sel, output logic [31:0] d);
    @(negedge clk);
    reg_sel = sel;
    #1 d = reg_rdata;
  endtask
  task automatic px(input pabs_pix_in_t p);
    @(negedge clk);
    pix_in = p;
  endtask
endmodule
`default_nettype wire

// ### verif/test_pixel_alu_preblend_stencil.sv
`timescale 1ns/10ps
`default_nettype none
module test_pixel_alu_preblend_stencil;
  import pabs_pkg::*;
  logic clk, sys_rst, reg_wr, pix_we, pass_out, blk;
  logic [1:0] reg_sel;
  logic [2:0] op;
  logic [3:0] f, v;
  logic [7:0] sat_out, es, ob, a, b;
  logic [31:0] reg_wdata, reg_rdata, pix_wdata, rd, pb, sc;
  pabs_pix_in_t pix_in, p;
  pabs_unit_sel_t unit_sel [4];
  int fails, check_count;
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  pabs_alu_ctrl pabs_alu_ctrl_i (.clk, .sys_rst, .reg_wr, .reg_sel, .reg_wdata, .reg_rdata,
    .pix_in, .unit_sel, .sat_out, .pix_wdata, .pix_we, .pass_out, .unit3_blend_blocked(blk));
  pabs_ctrl_model pabs_ctrl_model_i (.clk, .reg_rdata, .reg_wr, .reg_sel, .reg_wdata, .pix_in);
  task automatic chk(input logic ok, input string s);
    check_count++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("[FAIL] %0t %s", $time, s);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  function automatic logic [3:0] sop(input logic [2:0] o, input logic [3:0] x, input logic [3:0] r);
    case (o)
      3'h0: return 4'h0;
      3'h1: return x;
      3'h2: return ~x;
      3'h3: return r;
      3'h4, 3'h6: return (x == 4'hf) ? x : x + 4'h1;
      default: return (x == 4'h0) ? x : x - 4'h1;
    endcase
  endfunction
  initial
  begin
    #200us;
    fails++;
    end_of_test();
  end
  initial
  begin
    sys_rst = 1'b1;
    fails = 0;
    check_count = 0;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    for (int s = 0; s < 4; s++)
    begin
      pabs_ctrl_model_i.rd(s[1:0], rd);
      chk(rd === (s == 0 ? 32'h0 : s == 1 ? 32'h00ff_0000 : s == 2 ? 32'h3330_0000 : 32'h0), "reset");
    end
    chk(blk === 1'b0, "unit 3 free after reset");
    p = '0;
    p.new_data = 32'hc35a_9612;
    p.old_data = 32'h71e2_0f84;
    p.extra = 4'h5;
    p.sat_enable = 1'b1;
    p.pass_in = 2'h3;
    p.match_pass = 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      pb = {2'b00, k[1:0], 28'hc09_0401};
      pabs_ctrl_model_i.wr(REG_PREBLEND, pb);
      pabs_ctrl_model_i.rd(REG_PREBLEND, rd);
      chk(rd === pb, "preblend readback");
      p.stateless = (k == 4);
      pabs_ctrl_model_i.px(p);
      #1;
      if (k == 4)
        pb = 32'h0;
      a = p.new_data[31:24];
      b = ~p.old_data[31:24];
      es = pb[29] ? (pb[28] ? b : ~b) : (pb[28] ? a : (a < b ? a : b));
      chk(sat_out === es, "saturate output");
      for (int n = 0; n < 4; n++)
      begin
        f = pb[8*n+:4];
        ob = p.old_data[8*n+:8];
        chk(unit_sel[n] === {p.new_data[8*n+:8], p.extra[n], p.new_data[8*n+:8],
          f[3] ? es : f[2] ? ~ob : ob, f[0]}, "unit steering");
      end
    end
    p.stateless = 1'b0;
    p.st_ref = 8'h28;
    p.rop_result = 32'h42ff_ffff;
    pabs_ctrl_model_i.px(p);
    pabs_ctrl_model_i.wr(REG_ST_PLANES, 32'h3cff_0000);
    chk(blk === 1'b1, "unit 3 blocked");
    for (int c = 0; c < 3; c++)
      for (int k = 0; k < 24; k++)
      begin
        op = 3'(k / 3);
        v = (k % 3 == 0) ? 4'h0 : (k % 3 == 1) ? 4'h6 : 4'hf;
        sc = (c == 0) ? 32'h0114_0000 : (c == 1) ? 32'h1010_0000 : 32'h1100_0000;
        sc[28-4*c+:3] = op;
        pabs_ctrl_model_i.wr(REG_ST_CTRL, sc);
        p.old_data = {2'b10, v, 2'b01, 24'h00_e284};
        p.mag_pass = (c != 1);
        pabs_ctrl_model_i.px(p);
        @(negedge clk);
        ob = (c == 2) ? p.rop_result[31:24] : p.old_data[31:24];
        chk(pix_wdata[31:24] === {ob[7:6], sop(op, v, p.st_ref[5:2]), ob[1:0]} && pix_we === 1'b1
          && pass_out === (c == 2), "stencil op");
      end
    pabs_ctrl_model_i.wr(REG_ST_PLANES, 32'h3c0c_0000);
    p.old_data = 32'h1800_0000;
    p.mag_pass = 1'b1;
    for (int k = 0; k < 24; k++)
    begin
      p.st_ref = (k < 8) ? 8'h24 : (k < 16) ? 8'hcb : 8'h2c;
      pabs_ctrl_model_i.wr(REG_ST_CTRL, {13'h0, k[2:0], 16'h0});
      pabs_ctrl_model_i.px(p);
      @(negedge clk);
      sc = {8'h0, 8'h4b, 8'h2d, 8'he1};
      chk(pass_out === sc[k], "stencil compare");
    end
    p.pass_in = 2'h1;
    pabs_ctrl_model_i.px(p);
    @(negedge clk);
    chk(pass_out === 1'b0 && pix_we === 1'b0, "gate closed");
    p.pass_in = 2'h3;
    p.stateless = 1'b1;
    pabs_ctrl_model_i.px(p);
    @(negedge clk);
    chk(pass_out === 1'b1 && pix_we === 1'b1 && pix_wdata === p.rop_result, "stateless compare");
    pabs_ctrl_model_i.wr(2'h3, 32'h1234_0000);
    pabs_ctrl_model_i.rd(2'h3, rd);
    chk(rd === 32'h0, "unmapped read");
    end_of_test();
  end
endmodule
`default_nettype wire
